// file: measured_value_filter_error_hold.v
// What this block does
// - in median mode each new sample triggers a sort of the newest N values and the middle one is output.
// - for an even median width the two middle sorted values are added and halved.
// - median width is set by software to any value from three to nine samples.
// - moving average mode outputs the mean of the last N samples, N a power of two from 2 up.
// - each new sample enters the moving window while the oldest one leaves it.
// - recursive mode outputs (sample + (N-1) * previous output) / N with N from 1 to 32768.
// - with error output selected an invalid cycle yields the error value instead of a measurement.
// - with hold selected the last valid value repeats for a set number of invalid cycles, then error.
// - with hold forever selected the last valid value repeats on every invalid cycle.
// - with synchronisation off any rate from 0.4 kHz to 80 kHz is accepted.
// - with synchronisation on only the rates 1.5, 2.5, 5, 10, 20, 30 and 50 kHz are accepted.
// - moving average widths are powers of two only, at most 1024.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "mvf_defs.vh"
module measured_value_filter_error_hold #(
  parameter W = 16,
  parameter MAX_LOG = 10,
  parameter MED_DEPTH = 9
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire [W-1:0] raw_sample_in,
  input wire sample_valid_in,
  input wire sample_ok_in,
  output reg [W-1:0] result_out,
  output reg result_valid_out,
  output reg result_error_out,
  output reg busy_out,
  output reg meas_tick_out
);
  localparam NUM_W = W + 16;
  localparam [5:0] DIV_LAST = NUM_W - 1;
  localparam [3:0] MAX_LOG4 = MAX_LOG;
  localparam [2:0] ST_IDLE = 3'b001, ST_WAIT = 3'b010, ST_DIV = 3'b100;

  reg [1:0] mode, errm, sync;
  reg [3:0] mavg_log, med_n;
  reg [15:0] ravg_n, hold_lim, hold_cnt;
  reg [16:0] rate, rem;
  reg rejected, overrun, clr;
  reg [2:0] state, next_state;
  reg have_good, rec_init;
  reg [W-1:0] last_good, prev, go_val;
  reg [NUM_W-1:0] num;
  reg [5:0] cnt;
  reg [27:0] acc;
  reg go, go_err, go_hold, rec_first, start_div;
  reg [31:0] next_rdata;

  wire [W-1:0] mov_avg, med_val;
  wire take = (state == ST_IDLE) && sample_valid_in && sample_ok_in;
  wire mov_take = take && (mode == `MODE_MOV);
  wire med_take = take && (mode == `MODE_MED);

  // recursive numerator, sized so that N * full scale cannot overflow
  wire [NUM_W-1:0] rec_num = {16'h0000, raw_sample_in}
    + ({16'h0000, prev} * {{(NUM_W-16){1'b0}}, ravg_n - 16'h0001});
  wire [16:0] rem_sh = {rem[15:0], num[NUM_W-1]};
  wire [16:0] div17 = {1'b0, ravg_n};
  wire fits = rem_sh >= div17;
  wire [NUM_W-1:0] quot = {num[NUM_W-2:0], fits};
  wire [27:0] acc_sum = acc + {11'h000, rate};

  function rate_ok;
    input [1:0] s;
    input [16:0] r;
    begin
      if (s == `SYNC_OFF)
        rate_ok = (r >= `RATE_MIN) && (r <= `RATE_MAX);
      else
        rate_ok = (r == `RATE_S0) || (r == `RATE_S1) || (r == `RATE_S2)
          || (r == `RATE_S3) || (r == `RATE_S4) || (r == `RATE_S5)
          || (r == `RATE_S6);
    end
  endfunction

  // legality of a write to each checked register
  wire ctrl_ok = rate_ok(wdata_in[`F_SYNC], rate) && (wdata_in[`F_ERRM] != 2'h3);
  wire mavg_ok = (wdata_in[3:0] >= `MAVG_LOG_MIN) && (wdata_in[3:0] <= MAX_LOG4);
  wire ravg_ok = (wdata_in[15:0] >= `RAVG_MIN) && (wdata_in[15:0] <= `RAVG_MAX);
  wire med_ok = (wdata_in[3:0] >= `MED_MIN) && (wdata_in[3:0] <= `MED_MAX);
  wire rate_wr_ok = (wdata_in[31:17] == 15'h0000) && rate_ok(sync, wdata_in[16:0]);

  mvf_moving_avg #(
    .W(W),
    .MAX_LOG(MAX_LOG)
  ) u_mov (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .clear_in(clr),
    .take_in(mov_take),
    .sample_in(raw_sample_in),
    .log_n_in(mavg_log),
    .avg_out(mov_avg)
  );

  mvf_median #(
    .W(W),
    .MAXN(MED_DEPTH)
  ) u_med (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .clear_in(clr),
    .take_in(med_take),
    .sample_in(raw_sample_in),
    .n_in(med_n),
    .med_out(med_val)
  );

  // register writes; an illegal setting is refused and flagged
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      mode <= `RST_MODE;
      errm <= `RST_ERRM;
      sync <= `RST_SYNC;
      mavg_log <= `RST_MAVG;
      ravg_n <= `RST_RAVG;
      med_n <= `RST_MED;
      hold_lim <= `RST_HOLD;
      rate <= `RST_RATE;
      rejected <= 1'b0;
      clr <= 1'b0;
    end
    else
    begin
      clr <= 1'b0;
      if (wr_in)
      begin
        case (addr_in)
          `A_CTRL:
          begin
            rejected <= !ctrl_ok;
            clr <= ctrl_ok;
            if (ctrl_ok)
            begin
              mode <= wdata_in[`F_MODE];
              errm <= wdata_in[`F_ERRM];
              sync <= wdata_in[`F_SYNC];
            end
          end
          `A_MAVG:
          begin
            rejected <= !mavg_ok;
            clr <= mavg_ok;
            if (mavg_ok)
              mavg_log <= wdata_in[3:0];
          end
          `A_RAVG:
          begin
            rejected <= !ravg_ok;
            clr <= ravg_ok;
            if (ravg_ok)
              ravg_n <= wdata_in[15:0];
          end
          `A_MED:
          begin
            rejected <= !med_ok;
            clr <= med_ok;
            if (med_ok)
              med_n <= wdata_in[3:0];
          end
          `A_HOLD:
            hold_lim <= wdata_in[15:0];
          `A_RATE:
          begin
            rejected <= !rate_wr_ok;
            if (rate_wr_ok)
              rate <= wdata_in[16:0];
          end
          default:
            rejected <= rejected;
        endcase
      end
    end
  end

  // read data for one cycle only, zero otherwise
  always @*
  begin
    next_rdata = 32'h00000000;
    if (rd_in)
    begin
      case (addr_in)
        `A_CTRL:
          next_rdata[5:0] = {sync, errm, mode};
        `A_MAVG:
          next_rdata[3:0] = mavg_log;
        `A_RAVG:
          next_rdata[15:0] = ravg_n;
        `A_MED:
          next_rdata[3:0] = med_n;
        `A_HOLD:
          next_rdata[15:0] = hold_lim;
        `A_RATE:
          next_rdata[16:0] = rate;
        `A_STATUS:
          next_rdata[19:0] = {rejected, overrun, have_good, busy_out, hold_cnt};
        `A_RESULT:
        begin
          next_rdata[W-1:0] = result_out;
          next_rdata[31] = result_error_out;
        end
        default:
          next_rdata = 32'h00000000;
      endcase
    end
  end

  // sequencing of one sample through the selected stage
  always @*
  begin
    next_state = state;
    go = 1'b0;
    go_err = 1'b0;
    go_hold = 1'b0;
    go_val = raw_sample_in;
    rec_first = 1'b0;
    start_div = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (sample_valid_in)
        begin
          if (!sample_ok_in)
          begin
            go = 1'b1;
            if (errm == `ERRM_HOLD && have_good && hold_cnt < hold_lim)
              go_hold = 1'b1;
            else if (errm == `ERRM_FOREVER && have_good)
              go_hold = 1'b1;
            else
              go_err = 1'b1;
          end
          else if (mode == `MODE_MOV || mode == `MODE_MED)
            next_state = ST_WAIT;
          else if (mode == `MODE_REC && rec_init)
          begin
            next_state = ST_DIV;
            start_div = 1'b1;
          end
          else
          begin
            go = 1'b1;
            rec_first = (mode == `MODE_REC);
          end
        end
      end
      ST_WAIT:
      begin
        go = 1'b1;
        go_val = (mode == `MODE_MOV) ? mov_avg : med_val;
        next_state = ST_IDLE;
      end
      ST_DIV:
      begin
        if (cnt == DIV_LAST)
        begin
          go = 1'b1;
          go_val = quot[W-1:0];
          next_state = ST_IDLE;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= ST_IDLE;
      result_out <= {W{1'b0}};
      result_valid_out <= 1'b0;
      result_error_out <= 1'b0;
      busy_out <= 1'b0;
      have_good <= 1'b0;
      last_good <= {W{1'b0}};
      hold_cnt <= 16'h0000;
      rec_init <= 1'b0;
      prev <= {W{1'b0}};
      num <= {NUM_W{1'b0}};
      rem <= 17'h00000;
      cnt <= 6'h00;
      overrun <= 1'b0;
      rdata_out <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      busy_out <= (next_state != ST_IDLE);
      result_valid_out <= go;
      rdata_out <= next_rdata;
      // a sample lost while busy wins over the clear by a status read
      if (sample_valid_in && state != ST_IDLE)
        overrun <= 1'b1;
      else if (rd_in && addr_in == `A_STATUS)
        overrun <= 1'b0;
      if (go)
      begin
        if (go_err)
        begin
          result_out <= {W{1'b1}};
          result_error_out <= 1'b1;
        end
        else if (go_hold)
        begin
          result_out <= last_good;
          result_error_out <= 1'b0;
          if (hold_cnt != 16'hFFFF)
            hold_cnt <= hold_cnt + 16'h0001;
        end
        else
        begin
          result_out <= go_val;
          result_error_out <= 1'b0;
          last_good <= go_val;
          have_good <= 1'b1;
          hold_cnt <= 16'h0000;
          prev <= go_val;
        end
      end
      if (rec_first)
        rec_init <= 1'b1;
      else if (clr)
        rec_init <= 1'b0;
      if (start_div)
      begin
        num <= rec_num;
        rem <= 17'h00000;
        cnt <= 6'h00;
      end
      else if (state == ST_DIV)
      begin
        rem <= fits ? rem_sh - div17 : rem_sh;
        num <= quot;
        cnt <= cnt + 6'h01;
      end
    end
  end

  // measuring clock from the rate setting by a phase accumulator
  wire acc_wrap = acc_sum >= `CLK_HZ;
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      acc <= 28'h0000000;
      meas_tick_out <= 1'b0;
    end
    else
    begin
      acc <= acc_wrap ? acc_sum - `CLK_HZ : acc_sum;
      meas_tick_out <= acc_wrap;
    end
  end
endmodule

// file: mvf_defs.vh
// register map, field layout, reset values and constants of the measured value filter
`ifndef MVF_DEFS_VH
`define MVF_DEFS_VH
`define A_CTRL 8'h00
`define A_MAVG 8'h04
`define A_RAVG 8'h08
`define A_MED 8'h0C
`define A_HOLD 8'h10
`define A_RATE 8'h14
`define A_STATUS 8'h18
`define A_RESULT 8'h1C
`define F_MODE 1:0
`define F_ERRM 3:2
`define F_SYNC 5:4
`define MODE_NONE 2'h0
`define MODE_MOV 2'h1
`define MODE_REC 2'h2
`define MODE_MED 2'h3
`define ERRM_OUT 2'h0
`define ERRM_HOLD 2'h1
`define ERRM_FOREVER 2'h2
`define SYNC_OFF 2'h0
`define RST_MODE 2'h0
`define RST_ERRM 2'h0
`define RST_SYNC 2'h0
`define RST_MAVG 4'h1
`define RST_RAVG 16'h0001
`define RST_MED 4'h3
`define RST_HOLD 16'h0001
`define RST_RATE 17'h02710
`define MAVG_LOG_MIN 4'h1
`define RAVG_MIN 16'h0001
`define RAVG_MAX 16'h8000
`define MED_MIN 4'h3
`define MED_MAX 4'h9
`define RATE_MIN 17'h00190
`define RATE_MAX 17'h13880
`define RATE_S0 17'h005DC
`define RATE_S1 17'h009C4
`define RATE_S2 17'h01388
`define RATE_S3 17'h02710
`define RATE_S4 17'h04E20
`define RATE_S5 17'h07530
`define RATE_S6 17'h0C350
`define CLK_HZ 28'h5F5E100
`endif

// file: mvf_moving_avg.v
// moving average over a power-of-two window stored in flip-flops
`timescale 1ns/1ps
module mvf_moving_avg #(
  parameter W = 16,
  parameter MAX_LOG = 10
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire clear_in,
  input wire take_in,
  input wire [W-1:0] sample_in,
  input wire [3:0] log_n_in,
  output reg [W-1:0] avg_out
);
  localparam DEPTH = 1 << MAX_LOG;
  localparam SW = W + MAX_LOG;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [MAX_LOG-1:0] wp;
  reg [MAX_LOG:0] fill;
  reg [SW-1:0] sum;
  wire [MAX_LOG:0] n_now = {{MAX_LOG{1'b0}}, 1'b1} << log_n_in;
  wire [MAX_LOG-1:0] old_idx = wp - n_now[MAX_LOG-1:0];
  // until the window is full the missing samples count as zero
  wire [W-1:0] oldest = (fill >= n_now) ? mem[old_idx] : {W{1'b0}};
  wire [SW-1:0] next_sum = sum + {{MAX_LOG{1'b0}}, sample_in} - {{MAX_LOG{1'b0}}, oldest};
  wire [SW-1:0] scaled = next_sum >> log_n_in;

  always @(posedge mclk_in)
  begin
    if (take_in)
      mem[wp] <= sample_in;
  end

  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      wp <= {MAX_LOG{1'b0}};
      fill <= {(MAX_LOG+1){1'b0}};
      sum <= {SW{1'b0}};
      avg_out <= {W{1'b0}};
    end
    else if (clear_in)
    begin
      wp <= {MAX_LOG{1'b0}};
      fill <= {(MAX_LOG+1){1'b0}};
      sum <= {SW{1'b0}};
    end
    else if (take_in)
    begin
      wp <= wp + {{(MAX_LOG-1){1'b0}}, 1'b1};
      sum <= next_sum;
      if (fill < n_now)
        fill <= fill + {{MAX_LOG{1'b0}}, 1'b1};
      avg_out <= scaled[W-1:0];
    end
  end
endmodule

// file: mvf_median.v
// median of the newest n samples, mean of the two middle ones for even n
`timescale 1ns/1ps
module mvf_median #(
  parameter W = 16,
  parameter MAXN = 9
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire clear_in,
  input wire take_in,
  input wire [W-1:0] sample_in,
  input wire [3:0] n_in,
  output reg [W-1:0] med_out
);
  reg [W-1:0] win [0:MAXN-1];
  reg [W-1:0] nw [0:MAXN-1];
  reg [3:0] rank;
  reg [W-1:0] lo;
  reg [W-1:0] hi;
  integer i;
  integer j;
  integer k;
  wire [3:0] lo_rank = (n_in - 4'h1) >> 1;
  wire [3:0] hi_rank = n_in >> 1;
  wire [W:0] pair = {1'b0, lo} + {1'b0, hi};

  // rank every sample of the window: ties broken by age, so ranks are unique
  always @*
  begin
    rank = 4'h0;
    lo = {W{1'b0}};
    hi = {W{1'b0}};
    nw[0] = sample_in;
    for (i = 1; i < MAXN; i = i + 1)
      nw[i] = win[i-1];
    for (i = 0; i < MAXN; i = i + 1)
    begin
      rank = 4'h0;
      for (j = 0; j < MAXN; j = j + 1)
        if (j < n_in && j != i && (nw[j] < nw[i] || (nw[j] == nw[i] && j < i)))
          rank = rank + 4'h1;
      if (i < n_in && rank == lo_rank)
        lo = nw[i];
      if (i < n_in && rank == hi_rank)
        hi = nw[i];
    end
  end

  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (k = 0; k < MAXN; k = k + 1)
        win[k] <= {W{1'b0}};
      med_out <= {W{1'b0}};
    end
    else if (clear_in)
    begin
      for (k = 0; k < MAXN; k = k + 1)
        win[k] <= {W{1'b0}};
    end
    else if (take_in)
    begin
      win[0] <= sample_in;
      for (k = 1; k < MAXN; k = k + 1)
        win[k] <= win[k-1];
      med_out <= pair[W:1];
    end
  end
endmodule

// file: mvf_chk.sv
// port-level assertions for the measured value filter
`timescale 1ns/1ps
module mvf_chk #(
  parameter W = 16
) (
  input wire mclk_in,
  input wire nrst_in,
  input wire [7:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  input wire [31:0] rdata_out,
  input wire [W-1:0] raw_sample_in,
  input wire sample_valid_in,
  input wire sample_ok_in,
  input wire [W-1:0] result_out,
  input wire result_valid_out,
  input wire result_error_out,
  input wire busy_out,
  input wire meas_tick_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!nrst_in);
  err_value_a: assert property (result_error_out |-> &result_out)
    else $error("error flag without error value");
  bad_take_a: assert property (sample_valid_in && !sample_ok_in && !busy_out |=> result_valid_out)
    else $error("invalid cycle gave no result");
  good_take_a: assert property (sample_valid_in && sample_ok_in && !busy_out |-> ##[1:33] result_valid_out)
    else $error("valid sample gave no result");
  busy_end_a: assert property ($fell(busy_out) |-> result_valid_out)
    else $error("busy ended without result");
  busy_len_a: assert property ($rose(busy_out) |-> ##[1:33] !busy_out)
    else $error("busy too long");
  res_cause_a: assert property (result_valid_out |-> $past(sample_valid_in) || $past(busy_out))
    else $error("result without sample");
  res_hold_a: assert property (!result_valid_out |-> $stable(result_out) && $stable(result_error_out))
    else $error("result changed without pulse");
  tick_pulse_a: assert property (meas_tick_out |=> !meas_tick_out)
    else $error("tick longer than one cycle");
  rd_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside read cycle");
  cover property (sample_valid_in && !sample_ok_in);
  cover property (result_valid_out && result_error_out);
  cover property ($rose(busy_out));
  cover property (meas_tick_out);
endmodule
bind measured_value_filter_error_hold mvf_chk #(.W(W)) chk_u (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .raw_sample_in(raw_sample_in),
  .sample_valid_in(sample_valid_in), .sample_ok_in(sample_ok_in), .result_out(result_out),
  .result_valid_out(result_valid_out), .result_error_out(result_error_out),
  .busy_out(busy_out), .meas_tick_out(meas_tick_out));

// file: sensor_model.sv
// behavioural model of the sensor feeding measured values
`timescale 1ns/1ps
module sensor_model (
  input wire mclk_in,
  input wire nrst_in,
  input wire go_in,
  input wire [15:0] value_in,
  input wire ok_in,
  output reg [15:0] raw_sample_out,
  output reg sample_valid_out,
  output reg sample_ok_out
);
  // outside a measurement cycle value and ok lines toggle so stale data is never trusted
  always @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      raw_sample_out <= 16'h0000;
      sample_valid_out <= 1'b0;
      sample_ok_out <= 1'b0;
    end
    else if (go_in)
    begin
      raw_sample_out <= value_in;
      sample_valid_out <= 1'b1;
      sample_ok_out <= ok_in;
    end
    else
    begin
      raw_sample_out <= ~raw_sample_out;
      sample_valid_out <= 1'b0;
      sample_ok_out <= ~sample_ok_out;
    end
  end
endmodule

// file: testbench.sv
// self-checking testbench of the measured value filter
`timescale 1ns/1ps
`include "mvf_defs.vh"
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin \
  errors = errors + 1; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
`define RC(a, e) begin rd(a, d); `CHK(d, e) end
module testbench;
  typedef struct packed {logic [15:0] v; logic o; logic [15:0] e; logic er;} row_t;
  reg mclk = 1'b0;
  reg nrst = 1'b0;
  reg [7:0] addr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg wr_s = 1'b0;
  reg rd_s = 1'b0;
  reg go = 1'b0;
  reg [15:0] val = 16'h0000;
  reg ok = 1'b0;
  wire [31:0] rdata;
  wire [15:0] raw;
  wire [15:0] res;
  wire sv, sok, rv, rerr, busy, tick;
  integer errors = 0;
  integer n_compared = 0;
  integer i, j, n_tick;
  reg [31:0] d;
  row_t rows [0:3] = '{'{16'h1234, 1'b1, 16'h1234, 1'b0}, '{16'h5555, 1'b0, 16'hFFFF, 1'b1},
    '{16'h0000, 1'b1, 16'h0000, 1'b0}, '{16'hFFFE, 1'b1, 16'hFFFE, 1'b0}};
  reg [7:0] cfg_a [0:3] = '{`A_MAVG, `A_MED, `A_MED, `A_RAVG};
  reg [31:0] cfg_v [0:3] = '{32'h2, 32'h5, 32'h4, 32'h4};
  reg [31:0] mode_v [0:3] = '{32'h1, 32'h3, 32'h3, 32'h2};
  reg [15:0] samp [0:4] = '{16'h0064, 16'h012C, 16'h012C, 16'h0190, 16'h01F4};
  reg [15:0] expv [0:19] = '{16'h0019, 16'h0064, 16'h00AF, 16'h0113, 16'h0177,
    16'h0000, 16'h0000, 16'h0064, 16'h012C, 16'h012C,
    16'h0000, 16'h0032, 16'h00C8, 16'h012C, 16'h015E,
    16'h0064, 16'h0096, 16'h00BB, 16'h00F0, 16'h0131};
  reg [31:0] rt [0:6] = '{32'h5DC, 32'h9C4, 32'h1388, 32'h2710, 32'h4E20, 32'h7530, 32'hC350};

  sensor_model model_u (.mclk_in(mclk), .nrst_in(nrst), .go_in(go), .value_in(val),
    .ok_in(ok), .raw_sample_out(raw), .sample_valid_out(sv), .sample_ok_out(sok));
  measured_value_filter_error_hold #(.W(16), .MAX_LOG(10), .MED_DEPTH(9)) dut_u (
    .mclk_in(mclk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
    .rd_in(rd_s), .rdata_out(rdata), .raw_sample_in(raw), .sample_valid_in(sv),
    .sample_ok_in(sok), .result_out(res), .result_valid_out(rv), .result_error_out(rerr),
    .busy_out(busy), .meas_tick_out(tick));

  always #5 mclk = ~mclk;

  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_s <= 1'b1;
      @(posedge mclk);
      wr_s <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, output [31:0] q);
    begin
      @(posedge mclk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk);
      rd_s <= 1'b0;
      #1;
      q = rdata;
    end
  endtask

  // one measurement through the sensor model, then wait for the result pulse
  task smp(input [15:0] v, input o, input [15:0] e, input er);
    integer k;
    begin
      @(posedge mclk);
      go <= 1'b1;
      val <= v;
      ok <= o;
      @(posedge mclk);
      go <= 1'b0;
      k = 0;
      @(posedge mclk);
      #1;
      while (rv !== 1'b1 && k < 50)
      begin
        @(posedge mclk);
        #1;
        k = k + 1;
      end
      `CHK(rv, 1'b1)
      `CHK(res, e)
      `CHK(rerr, er)
    end
  endtask

  task print_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial
  begin
    #800000;
    errors = errors + 1;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict;
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK({rv, rerr, busy, tick, res}, 20'h00000)
    `RC(`A_CTRL, 32'h0)
    `RC(`A_MAVG, 32'h1)
    `RC(`A_RAVG, 32'h1)
    `RC(`A_MED, 32'h3)
    `RC(`A_HOLD, 32'h1)
    `RC(`A_RATE, 32'h2710)
    `RC(8'h20, 32'h0)
    $display("test reset done");
    for (i = 0; i < 4; i = i + 1)
      smp(rows[i].v, rows[i].o, rows[i].e, rows[i].er);
    $display("test rows done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(cfg_a[i], cfg_v[i]);
      wr(`A_CTRL, mode_v[i]);
      for (j = 0; j < 5; j = j + 1)
        smp(samp[j], 1'b1, expv[i * 5 + j], 1'b0);
    end
    $display("test filters done");
    wr(`A_HOLD, 32'h2);
    wr(`A_CTRL, 32'h4);
    smp(16'h01F4, 1'b1, 16'h01F4, 1'b0);
    smp(16'h0001, 1'b0, 16'h01F4, 1'b0);
    smp(16'h0002, 1'b0, 16'h01F4, 1'b0);
    smp(16'h0003, 1'b0, 16'hFFFF, 1'b1);
    `RC(`A_RESULT, 32'h8000FFFF)
    smp(16'h02BC, 1'b1, 16'h02BC, 1'b0);
    smp(16'h0004, 1'b0, 16'h02BC, 1'b0);
    wr(`A_CTRL, 32'h8);
    smp(16'h0384, 1'b1, 16'h0384, 1'b0);
    for (i = 0; i < 4; i = i + 1)
      smp(16'h0005, 1'b0, 16'h0384, 1'b0);
    `RC(`A_STATUS, 32'h00020004)
    $display("test hold done");
    wr(`A_MED, 32'h2);
    `RC(`A_MED, 32'h4)
    rd(`A_STATUS, d);
    `CHK(d[19], 1'b1)
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`A_MED, 3 + 2 * i);
      `RC(`A_MED, 3 + 2 * i)
    end
    wr(`A_MED, 32'hA);
    `RC(`A_MED, 32'h9)
    wr(`A_MAVG, 32'h9);
    `RC(`A_MAVG, 32'h9)
    wr(`A_MAVG, 32'hB);
    `RC(`A_MAVG, 32'h9)
    wr(`A_MAVG, 32'hA);
    `RC(`A_MAVG, 32'hA)
    wr(`A_RAVG, 32'h8000);
    `RC(`A_RAVG, 32'h8000)
    wr(`A_RAVG, 32'h0);
    `RC(`A_RAVG, 32'h8000)
    wr(`A_RATE, 32'h190);
    wr(`A_RATE, 32'h18F);
    `RC(`A_RATE, 32'h190)
    wr(`A_RATE, 32'h13880);
    wr(`A_RATE, 32'h13881);
    `RC(`A_RATE, 32'h13880)
    wr(`A_CTRL, 32'h10);
    `RC(`A_CTRL, 32'h8)
    wr(`A_RATE, 32'h2710);
    wr(`A_CTRL, 32'h10);
    `RC(`A_CTRL, 32'h10)
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(`A_RATE, rt[i]);
      `RC(`A_RATE, rt[i])
    end
    wr(`A_RATE, 32'h2EE0);
    `RC(`A_RATE, 32'hC350)
    wr(`A_CTRL, 32'h1C);
    `RC(`A_CTRL, 32'h10)
    $display("test config done");
    wr(`A_MAVG, 32'h1);
    wr(`A_CTRL, 32'h11);
    @(posedge mclk);
    go <= 1'b1;
    val <= 16'h0100;
    ok <= 1'b1;
    @(posedge mclk);
    val <= 16'h0300;
    @(posedge mclk);
    go <= 1'b0;
    #1;
    `CHK(busy, 1'b1)
    @(posedge mclk);
    #1;
    `CHK({rv, busy, res}, 18'h20080)
    rd(`A_STATUS, d);
    `CHK(d[19:18], 2'b01)
    rd(`A_STATUS, d);
    `CHK(d[18], 1'b0)
    smp(16'h0200, 1'b1, 16'h0180, 1'b0);
    $display("test overrun done");
    n_tick = 0;
    repeat (10000)
    begin
      @(posedge mclk);
      #1;
      if (tick === 1'b1)
        n_tick = n_tick + 1;
    end
    `CHK((n_tick >= 4) && (n_tick <= 6), 1'b1)
    $display("test tick done");
    print_verdict;
  end
endmodule
